// ==== hdl/apdhr_pkg.sv ====
// Package of constants for the power-down aware parallel readout block.
//------------------------------------------------------------------------------
// Summary of operation
// - Power-down low stops all conversion, buffering and data-ready activity.
// - An undriven power-down pin reads as high, the inactive level.
// - Each result is an 18-bit parallel word driven onto the host bus.
// - Data-ready flags results; host treats it as an interrupt event.
// - When the set level of results is buffered, pulse data-ready high.
// - Reads give oldest result first, next one on each read falling edge.
//------------------------------------------------------------------------------
package apdhr_pkg;
    localparam int unsigned APDHR_DATA_W = 18;
    localparam int unsigned APDHR_FIFO_DEPTH = 8;
    localparam int unsigned APDHR_LEV_W = 3;
    // Data-ready period unit in master clocks; period is 32 * level when buffering, 32 otherwise.
    localparam int unsigned APDHR_BASE_PERIOD = 32;
    // Data-ready stays high for this many clocks when it pulses.
    localparam int unsigned APDHR_DATA_READY_N_PULSE = 4;
    localparam int unsigned APDHR_SKIP_PERIOD = 512;
    // Reference start-up time in microseconds, observed by the host.
    localparam int unsigned APDHR_REF_START_US = 15000;
    localparam int unsigned APDHR_CLK_MHZ = 40;
    localparam int unsigned APDHR_REF_START_CYC = APDHR_REF_START_US * APDHR_CLK_MHZ;
    localparam int unsigned APDHR_SETTLE_PERIODS = 100;
    typedef enum logic [2:0] {
        APDHR_ST_OFF = 3'h1,
        APDHR_ST_FILL = 3'h2,
        APDHR_ST_READ = 3'h4
    } apdhr_state_t;
endpackage : apdhr_pkg

// ==== hdl/apdhr_fifo.sv ====
// Small synchronous FIFO used to buffer conversion results.
`timescale 1ns/1ps
`default_nettype none
module apdhr_fifo #(
    parameter int unsigned WIDTH = 18,
    parameter int unsigned DEPTH = 8
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH+1)-1:0] count_o
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH+1);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] apdhr_inc(input logic [AW-1:0] p);
        apdhr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : apdhr_inc

    // Full and empty come from the occupancy count, so they never lie.
    assign in_ready_o = (cnt_q != CW'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_q[rd_q];
    assign count_o = cnt_q;

    // Storage is written only on an accepted push.
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // Pointers and count; flush empties the buffer at once.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (flush_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= apdhr_inc(wr_q);
            end
            if (pop) begin
                rd_q <= apdhr_inc(rd_q);
            end
            cnt_q <= cnt_q + CW'(push) - CW'(pop);
        end
    end
endmodule : apdhr_fifo
`default_nettype wire

// ==== hdl/apdhr_top.sv ====
// Power-down handling and parallel host readout of the converter results.
`timescale 1ns/1ps
`default_nettype none
module apdhr_top
    import apdhr_pkg::*;
#(
    parameter int unsigned DATA_W = APDHR_DATA_W,
    parameter int unsigned FIFO_DEPTH = APDHR_FIFO_DEPTH
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic power_down_n_i,
    input wire logic power_down_n_oe_i,
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic [APDHR_LEV_W-1:0] buffer_depth_select_i,
    input wire logic sample_valid_i,
    input wire logic [DATA_W-1:0] sample_data_i,
    output logic sample_ready_o,
    output logic data_ready_n_o,
    output logic [DATA_W-1:0] dout_o,
    output logic dout_oe_o,
    output logic active_o
);
    localparam int unsigned CW = $clog2(FIFO_DEPTH+1);
    localparam int unsigned PW = 10;

    //--------------------------------------------------------------------------
    // Pin synchronisers
    //--------------------------------------------------------------------------
    logic [1:0] pd_s_q;
    logic [1:0] rd_s_q;
    logic [1:0] cs_s_q;
    logic rd_d1_q;
    logic pd_pin;
    logic pd_n;
    logic rd_n;
    logic cs_n;
    logic rd_fall;

    // Released power-down pin counts as high, like a weak pull-up.
    // Undriven pin high.
    assign pd_pin = power_down_n_oe_i ? power_down_n_i : 1'b1;

    // Two flops on every pin; logic reads the second stage, and a third flop on read feeds the edge detect.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pd_s_q <= 2'h3;
            rd_s_q <= 2'h3;
            cs_s_q <= 2'h3;
            rd_d1_q <= 1'b1;
        end else begin
            pd_s_q <= {pd_s_q[0], pd_pin};
            rd_s_q <= {rd_s_q[0], rd_n_i};
            cs_s_q <= {cs_s_q[0], cs_n_i};
            rd_d1_q <= rd_s_q[1];
        end
    end
    assign pd_n = pd_s_q[1];
    assign rd_n = rd_s_q[1];
    assign cs_n = cs_s_q[1];
    assign rd_fall = rd_d1_q && !rd_n;

    //--------------------------------------------------------------------------
    // Level decode and buffer
    //--------------------------------------------------------------------------
    logic [CW-1:0] level;
    logic fifo_mode;
    logic [PW-1:0] period;
    logic f_valid;
    logic f_pop;
    logic [DATA_W-1:0] f_data;
    logic [CW-1:0] f_count;
    logic flush;

    // Level is twice the select code, capped by the buffer depth.
    function automatic logic [CW-1:0] apdhr_level(input logic [2:0] sel);
        logic [4:0] l;
        l = {1'b0, sel, 1'b0};
        apdhr_level = (l > 5'(FIFO_DEPTH)) ? CW'(FIFO_DEPTH) : CW'(l);
    endfunction : apdhr_level

    assign level = apdhr_level(buffer_depth_select_i);
    assign fifo_mode = (buffer_depth_select_i != 3'h0);
    assign period = fifo_mode ? PW'(APDHR_BASE_PERIOD) * PW'(level)
                              : PW'(APDHR_BASE_PERIOD);
    assign flush = !pd_n;

    apdhr_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .flush_i(flush),
        .in_valid_i(sample_valid_i && pd_n),
        .in_ready_o(sample_ready_o),
        .in_data_i(sample_data_i),
        .out_valid_o(f_valid),
        .out_ready_i(f_pop),
        .out_data_o(f_data),
        .count_o(f_count)
    );

    //--------------------------------------------------------------------------
    // Readback sequencing
    //--------------------------------------------------------------------------
    apdhr_state_t st_q;
    logic [CW-1:0] left_q;
    logic [PW-1:0] tick_q;
    logic [2:0] pulse_q;
    logic ready_evt;

    // Without buffering one result is ready per word; otherwise a full level.
    // Level reached event.
    assign ready_evt = (st_q == APDHR_ST_FILL) && (f_count >= 
        (fifo_mode ? level : CW'(1)));
    // Each read falling edge while selected in the readback state takes one word.
    // One word per read.
    // Power-down blocks the pop, so a flush never races a read.
    assign f_pop = (st_q == APDHR_ST_READ) && rd_fall && !cs_n && f_valid
        && pd_n;

    // Sequencer; power-down forces the idle state ahead of everything.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= APDHR_ST_FILL;
            left_q <= '0;
        end else begin
            case (st_q)
                APDHR_ST_OFF: begin
                    if (pd_n) begin
                        st_q <= APDHR_ST_FILL;
                    end
                end
                APDHR_ST_FILL: begin
                    if (!pd_n) begin
                        st_q <= APDHR_ST_OFF;
                    end else if (ready_evt) begin
                        st_q <= APDHR_ST_READ;
                        left_q <= fifo_mode ? level : CW'(1);
                    end
                end
                APDHR_ST_READ: begin
                    if (!pd_n) begin
                        st_q <= APDHR_ST_OFF;
                    end else if (f_pop) begin
                        left_q <= left_q - 1'b1;
                        if (left_q == CW'(1)) begin
                            st_q <= APDHR_ST_FILL;
                        end
                    end
                end
                default: begin
                    st_q <= APDHR_ST_OFF;
                end
            endcase
        end
    end

    // Period tick free-runs and restarts on each level-reached event; it does not gate the data-ready pulse.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tick_q <= '0;
            pulse_q <= '0;
        end else if (!pd_n) begin
            tick_q <= '0;
            pulse_q <= '0;
        end else begin
            tick_q <= (ready_evt || tick_q >= period) ? '0 : tick_q + 1'b1;
            if (ready_evt) begin
                pulse_q <= 3'(APDHR_DATA_READY_N_PULSE);
            end else if (pulse_q != '0) begin
                pulse_q <= pulse_q - 1'b1;
            end
        end
    end

    assign data_ready_n_o = (pulse_q != '0);

    // Output word is registered on each taken read, oldest first.
    // Oldest first order.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dout_o <= '0;
        end else if (f_pop) begin
            dout_o <= f_data;
        end
    end

    // Bus is driven only while selected and reading, to avoid contention.
    assign dout_oe_o = pd_n && !cs_n && !rd_n;
    assign active_o = pd_n && (st_q != APDHR_ST_OFF);

    //--------------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------------
    // Shut down quiet.
    pd_quiet_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !pd_n |=> (f_count == '0) && !active_o)
        else $error("power-down left buffer or activity");
    data_ready_n_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (ready_evt && pd_n) |=> data_ready_n_o [*4])
        else $error("data-ready pulse wrong length");
    read_pop_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        f_pop |=> (f_count == $past(f_count) - 1'b1) || $past(sample_valid_i))
        else $error("read did not take one word");
    read_data_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        f_pop |=> dout_o == $past(f_data))
        else $error("output is not the oldest word");
    bus_drive_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        dout_oe_o |-> $past(!rd_n_i, 2) && $past(!cs_n_i, 2))
        else $error("bus driven outside a read");
    pd_data_ready_n_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !pd_n |=> !data_ready_n_o)
        else $error("data-ready pulsed in power-down");
    pull_up_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !power_down_n_oe_i [*3] |-> pd_n)
        else $error("released power-down read as low");
    read_state_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (ready_evt && pd_n) |=> st_q == APDHR_ST_READ)
        else $error("no readback after data-ready");
    left_load_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (ready_evt && pd_n) |=> left_q != '0)
        else $error("readback count not loaded");
endmodule : apdhr_top
`default_nettype wire

// ==== dv/apdhr_host.sv ====
// Host reader model: answers data-ready with one strobed read per word.
`timescale 1ns/1ps
`default_nettype none
module apdhr_host (
    input wire logic core_clk_i,
    input wire logic data_ready_n_i,
    input wire logic [17:0] dout_i,
    input wire logic cs_block_i,
    input wire logic kick_i,
    input wire logic [3:0] level_i,
    output logic cs_n_o,
    output logic rd_n_o,
    output logic [17:0] word_o,
    output logic word_stb_o
);
    logic prev = 1'b0;

    // Idle bus: deselected, strobe high.
    initial begin
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        word_o = 18'h0;
        word_stb_o = 1'b0;
    end

    // Interrupt driven readback.
    // Reads exactly level words; the bench may force chip select off.
    always @(posedge core_clk_i) begin
        if ((data_ready_n_i === 1'b1 && prev !== 1'b1) || kick_i === 1'b1) begin
            for (int k = 0; k < level_i; k++) begin
                @(negedge core_clk_i);
                cs_n_o <= cs_block_i;
                rd_n_o <= 1'b0;
                // Strobe low well past the sync and register delay.
                repeat (6) @(negedge core_clk_i);
                word_o <= dout_i;
                word_stb_o <= 1'b1;
                rd_n_o <= 1'b1;
                @(negedge core_clk_i);
                word_stb_o <= 1'b0;
                cs_n_o <= 1'b1;
                repeat (3) @(negedge core_clk_i);
            end
        end
        prev <= data_ready_n_i;
    end
endmodule : apdhr_host
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the power-down aware readout block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import apdhr_pkg::*;
    logic core_clk = 1'b0;
    logic clk_run = 1'b1;
    logic rstn = 1'b0;
    logic pd_drv = 1'b1;
    logic pd_oe = 1'b1;
    logic [2:0] sel = 3'h1;
    logic valid = 1'b0;
    logic [17:0] data = 18'h0;
    logic cs_block = 1'b0;
    logic kick = 1'b0;
    logic [3:0] level = 4'h2;
    logic cs_n, rd_n, ready, data_ready_n, dout_oe, active, stb;
    logic [17:0] dout, word;
    int bad_count = 0;
    int comparisons = 0;
    logic [17:0] got_q[$];

    // Clock runs free except while parked during power-down.
    always #12.5 if (clk_run) core_clk = ~core_clk;

    apdhr_top apdhr_top_i (.core_clk_i(core_clk), .rstn_i(rstn),
        .power_down_n_i(pd_drv), .power_down_n_oe_i(pd_oe),
        .cs_n_i(cs_n), .rd_n_i(rd_n), .buffer_depth_select_i(sel),
        .sample_valid_i(valid), .sample_data_i(data),
        .sample_ready_o(ready), .data_ready_n_o(data_ready_n), .dout_o(dout),
        .dout_oe_o(dout_oe), .active_o(active));
    apdhr_host apdhr_host_i (.core_clk_i(core_clk), .data_ready_n_i(data_ready_n),
        .dout_i(dout), .cs_block_i(cs_block), .kick_i(kick),
        .level_i(level), .cs_n_o(cs_n), .rd_n_o(rd_n), .word_o(word),
        .word_stb_o(stb));

    // Each captured word also checks the bus was driven only if selected.
    always @(posedge core_clk) begin
        if (stb === 1'b1) begin
            got_q.push_back(word);
            chk({17'h0, dout_oe}, {17'h0, !cs_block});
        end
    end

    //--------------------------------------------------------------------
    // Shared tasks
    //--------------------------------------------------------------------
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic summarize();
        if (bad_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    // The select code changes only under reset, so the fill count starts clean.
    task automatic reset_dut(input logic [2:0] s, input logic [3:0] l);
        @(negedge core_clk);
        rstn = 1'b0;
        sel = s;
        level = 4'h1;
        repeat (20) @(negedge core_clk);
        rstn = 1'b1;
        // One read pulse after reset; the block is filling an empty buffer, so no word is taken.
        kick = 1'b1;
        @(negedge core_clk);
        kick = 1'b0;
        repeat (12) @(negedge core_clk);
        got_q.delete();
        level = l;
    endtask : reset_dut

    task automatic push(input int n, input logic [17:0] base);
        for (int k = 0; k < n; k++) begin
            @(negedge core_clk);
            valid = 1'b1;
            data = base + 18'(k);
            @(posedge core_clk);
            for (int t = 0; t < 50 && ready !== 1'b1; t++) @(posedge core_clk);
        end
        @(negedge core_clk);
        valid = 1'b0;
    endtask : push

    task automatic pulse_len();
        int w = 0;
        for (int t = 0; t < 600 && data_ready_n !== 1'b1; t++) @(posedge core_clk);
        while (data_ready_n === 1'b1 && w < 20) begin
            w++;
            @(posedge core_clk);
        end
        chk(18'(w), 18'(APDHR_DATA_READY_N_PULSE));
    endtask : pulse_len

    task automatic expect_words(input int n, input logic [17:0] base);
        for (int t = 0; t < 2000 && got_q.size() < n; t++) @(posedge core_clk);
        chk(18'(got_q.size()), 18'(n));
        for (int k = 0; k < n && k < got_q.size(); k++) begin
            chk(got_q[k], base + 18'(k));
        end
        got_q.delete();
    endtask : expect_words

    //--------------------------------------------------------------------
    // Scenarios
    //--------------------------------------------------------------------
    task automatic s_level2();
        reset_dut(3'h1, 4'h2);
        push(2, 18'h3ff00);
        pulse_len();
        expect_words(2, 18'h3ff00);
    endtask : s_level2

    // Full buffer refuses input, then drains oldest first.
    task automatic s_full();
        reset_dut(3'h4, 4'h8);
        push(8, 18'h2aaa0);
        chk({17'h0, ready}, 18'h0);
        pulse_len();
        expect_words(8, 18'h2aaa0);
    endtask : s_full

    // A read with chip select high is ignored; the next one is taken.
    task automatic s_select();
        reset_dut(3'h0, 4'h1);
        cs_block = 1'b1;
        push(1, 18'h15555);
        pulse_len();
        expect_words(1, 18'h0);
        @(negedge core_clk);
        cs_block = 1'b0;
        repeat (5) @(negedge core_clk);
        kick = 1'b1;
        @(negedge core_clk);
        kick = 1'b0;
        expect_words(1, 18'h15555);
    endtask : s_select

    // No data-ready while powered down; floating pin wakes the block.
    task automatic s_power();
        int hi = 0;
        reset_dut(3'h1, 4'h2);
        pd_drv = 1'b0;
        repeat (6) @(negedge core_clk);
        chk({17'h0, active}, 18'h0);
        valid = 1'b1;
        for (int t = 0; t < 100; t++) begin
            @(posedge core_clk);
            if (data_ready_n !== 1'b0) hi++;
        end
        chk(18'(hi), 18'h0);
        @(negedge core_clk);
        valid = 1'b0;
        // Master clock parked low while powered down, then restarted.
        clk_run = 1'b0;
        #240;
        clk_run = 1'b1;
        @(negedge core_clk);
        chk({17'h0, active}, 18'h0);
        // Released pin stays low here, so only the pull-up can wake the block.
        pd_oe = 1'b0;
        repeat (6) @(negedge core_clk);
        chk({17'h0, active}, 18'h1);
        // Buffered mode needs a reset after wake.
        reset_dut(3'h1, 4'h2);
        // Reference start-up wait, scaled down to keep the run short.
        repeat (40) @(negedge core_clk);
        // First readback after settling is read and thrown away.
        push(2, 18'h00000);
        for (int t = 0; t < 200 && got_q.size() < 2; t++) @(posedge core_clk);
        got_q.delete();
        repeat (6) @(negedge core_clk);
        push(2, 18'h0c3c3);
        pulse_len();
        expect_words(2, 18'h0c3c3);
        pd_oe = 1'b1;
        pd_drv = 1'b1;
    endtask : s_power

    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        summarize();
    end

    initial begin
        s_level2();
        s_full();
        s_select();
        s_power();
        summarize();
    end
endmodule : testbench
`default_nettype wire
